// ---- common/ail_params.svh ----
// register map, field positions, reset values and widths of the limit and stop interlock
`ifndef AIL_PARAMS_SVH
`define AIL_PARAMS_SVH
`define AIL_CW 32
`define AIL_CFG 8'h00
`define AIL_CTRL 8'h04
`define AIL_OUT 8'h08
`define AIL_STAT 8'h0C
`define AIL_NOSE 8'h10
`define AIL_MECH 8'h28
`define AIL_END 8'h40
`define AIL_HLD 0
`define AIL_LVL 1
`define AIL_STM 2
`define AIL_MSE 3
`define AIL_NSE 4
`define AIL_SCP 5
`define AIL_CSE 6
`define AIL_RSTQ 0
`define AIL_MREQ 8
`define AIL_CFG_RST 8'h1B
`define AIL_LPOS_RST 32'h7FFFFFFF
`define AIL_LNEG_RST 32'h80000000
`endif

// ---- common/ail_pkg.sv ----
// types shared by the limit and stop interlock
`include "ail_params.svh"
package ail_pkg;
    typedef logic [2:0][`AIL_CW-1:0] ail_vec_t;
    typedef logic [5:0][`AIL_CW-1:0] ail_lim_t;
    typedef enum logic [5:0] {
        AIL_EDIT = 6'h01, AIL_MAN = 6'h02, AIL_AUTO = 6'h04,
        AIL_DIAG = 6'h08, AIL_PARM = 6'h10, AIL_OFFS = 6'h20
    } ail_mode_e;
    typedef enum logic [1:0] {AIL_CS_IDLE = 2'h1, AIL_CS_RUN = 2'h2} ail_cs_e;
    typedef struct packed {
        logic [2:0] pos;
        logic [2:0] neg;
    } ail_jog_s;
    typedef struct packed {
        logic spindle;
        logic coolant;
        logic lube;
        logic chuck;
        logic tailstock;
        logic tool_fwd;
        logic tool_rev;
    } ail_aux_s;
    typedef struct packed {
        logic dry_run_exit;
        logic rapid_to_feed;
        logic prog_init;
        logic timer_restart;
    } ail_rel_s;
    typedef struct packed {
        logic [1:0] s1_lim;
        logic [1:0] s2_lim;
        logic s1_es;
        logic s2_es;
        logic [7:0] cfg;
        ail_lim_t nose_lim;
        ail_lim_t mech_lim;
        ail_aux_s aux;
        logic delay;
        logic hl_pos;
        logic hl_neg;
        logic mech_p;
        logic mech_n;
        logic nose_p;
        logic nose_n;
        logic es_act;
        logic es_show;
        ail_mode_e mode;
        ail_mode_e saved;
        logic chuck_clamp;
        logic tail_adv;
        logic [3:0] unsure;
        logic seq_abort;
        ail_cs_e cs;
        logic cs_start;
        logic cs_abort;
        logic hard_stop;
        logic decel_stop;
        logic prog_halt;
        logic pos_block;
        logic neg_block;
        ail_rel_s rel;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } ail_st_s;
endpackage

// ---- hw/ail_interlock.sv ----
// limit, soft-limit and emergency-stop interlock with an APB register slave
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "ail_params.svh"
// Function
// - hard limits checked only when detection enabled
// - level one: open series chain raises alarm
// - level zero: closed parallel switch raises alarm
// - mode bit selects hard-limit reaction
// - mode one halts abruptly on limit
// - limit hit stops feed, halts program, aux kept
// - positive alarm blocks positive motion, vice versa
// - machine coordinate outside stroke raises alarm
// - nose coordinate outside stroke raises alarm
// - soft-limit crossing decelerates axes to stop
// - opposite manual motion clears overtravel alarm
// - six nose stroke limits, Z X Y
// - six mechanical stroke limits, Z X Y
// - separate enables for mechanical, nose soft limits
// - stop input halts feed, spindle, coolant, lube
// - reset after release restores previous mode
// - held stop refuses manual, auto, diagnosis
// - stop stores chuck released, tailstock retracted
// - stop aborts sequences, marks positions uncertain
// - delay output held during stop
// - scope bit picks cleared output set
// - release leaves dry run, rapid, restores init
// - release restarts pressure and lube timers
// - custom stop sequence runs once if enabled and stopped in manual or auto
// - custom sequence aborts on alarm or step stop
module ail_interlock (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pos_limit_in,
    input wire logic neg_limit_in,
    input wire logic emergency_stop_in,
    input wire ail_pkg::ail_vec_t mach_crd,
    input wire ail_pkg::ail_vec_t nose_crd,
    input wire ail_pkg::ail_jog_s jog,
    input wire logic [3:0] seq_busy,
    input wire logic [3:0] seq_done,
    input wire logic foot_chuck,
    input wire logic foot_tail,
    input wire logic cust_present,
    input wire logic cust_step_stop,
    input wire logic cust_done,
    output ail_pkg::ail_aux_s aux_out,
    output logic delay_interface_out,
    output logic hard_stop,
    output logic decel_stop,
    output logic prog_halt,
    output logic pos_block,
    output logic neg_block,
    output logic estop_alarm,
    output logic seq_abort,
    output logic [3:0] pos_uncertain,
    output logic chuck_clamp_state,
    output logic tailstock_advance_state,
    output ail_pkg::ail_rel_s release_act,
    output logic cust_start,
    output logic cust_abort,
    output logic cust_run
);
    import ail_pkg::*;

    ail_st_s st;
    ail_st_s next_st;

    // {above, below} over all three axes; limits stored pos then neg per axis
    function automatic logic [1:0] out_rng(ail_vec_t c, ail_lim_t l);
        logic [1:0] r;
        r = 2'h0;
        for (int a = 0; a < 3; a++) begin
            if ($signed(c[a]) > $signed(l[2*a])) begin
                r[1] = 1'b1;
            end
            if ($signed(c[a]) < $signed(l[2*a+1])) begin
                r[0] = 1'b1;
            end
        end
        return r;
    endfunction

    logic lim_p, lim_n, es_in, man, hit_p, hit_n, clr_p, clr_n;
    logic wr, rd_setup, es_enter, rst_req, alarm_any, mapped;
    logic [1:0] m_rng, n_rng;
    logic [5:0] idx;

    always_comb begin
        next_st = st;
        lim_p = st.s2_lim[1];
        lim_n = st.s2_lim[0];
        es_in = st.s2_es;
        man = (st.mode == AIL_MAN);
        idx = paddr[7:2];
        mapped = (paddr < `AIL_END) && (paddr[1:0] == 2'h0);
        wr = psel && penable && pwrite && st.ready && mapped;
        rd_setup = psel && !penable;
        rst_req = wr && (paddr == `AIL_CTRL) && pwdata[`AIL_RSTQ];
        // two stages before any use; stage one feeds only stage two
        next_st.s1_lim = {pos_limit_in, neg_limit_in};
        next_st.s2_lim = st.s1_lim;
        next_st.s1_es = emergency_stop_in;
        next_st.s2_es = st.s1_es;

        hit_p = st.cfg[`AIL_LVL] ? lim_p : !lim_p;
        hit_n = st.cfg[`AIL_LVL] ? lim_n : !lim_n;
        // moving away in manual clears; still on the switch re-sets at once
        clr_p = man && (|jog.neg);
        clr_n = man && (|jog.pos);
        next_st.hl_pos = st.cfg[`AIL_HLD] && (hit_p || (st.hl_pos && !clr_p));
        next_st.hl_neg = st.cfg[`AIL_HLD] && (hit_n || (st.hl_neg && !clr_n));

        m_rng = out_rng(mach_crd, st.mech_lim);
        n_rng = out_rng(nose_crd, st.nose_lim);
        next_st.mech_p = st.cfg[`AIL_MSE] && (m_rng[1] || (st.mech_p && !clr_p));
        next_st.mech_n = st.cfg[`AIL_MSE] && (m_rng[0] || (st.mech_n && !clr_n));
        next_st.nose_p = st.cfg[`AIL_NSE] && (n_rng[1] || (st.nose_p && !clr_p));
        next_st.nose_n = st.cfg[`AIL_NSE] && (n_rng[0] || (st.nose_n && !clr_n));

        next_st.pos_block = st.hl_pos || st.mech_p || st.nose_p;
        next_st.neg_block = st.hl_neg || st.mech_n || st.nose_n;
        // abrupt halt loses position; decel is the gentler choice
        next_st.hard_stop = ((st.hl_pos || st.hl_neg) && st.cfg[`AIL_STM]) || st.es_act;
        next_st.decel_stop = st.mech_p || st.mech_n || st.nose_p || st.nose_n
            || ((st.hl_pos || st.hl_neg) && !st.cfg[`AIL_STM]);
        next_st.prog_halt = st.hl_pos || st.hl_neg || st.es_act;
        alarm_any = st.hl_pos || st.hl_neg || st.mech_p || st.mech_n || st.nose_p || st.nose_n;

        next_st.seq_abort = 1'b0;
        next_st.cs_start = 1'b0;
        next_st.cs_abort = 1'b0;
        next_st.rel = '0;

        // software aux writes; hard-limit hits leave these alone
        if (wr && paddr == `AIL_OUT) begin
            next_st.aux = ail_aux_s'(pwdata[6:0]);
            if (!st.es_act) begin
                next_st.delay = pwdata[7];
            end
        end
        if (wr && paddr == `AIL_CFG) begin
            next_st.cfg = pwdata[7:0];
        end
        if (wr && idx >= 6'(`AIL_NOSE >> 2) && idx < 6'(`AIL_MECH >> 2)) begin
            next_st.nose_lim[3'(idx - 6'(`AIL_NOSE >> 2))] = pwdata;
        end
        if (wr && idx >= 6'(`AIL_MECH >> 2) && idx < 6'(`AIL_END >> 2)) begin
            next_st.mech_lim[3'(idx - 6'(`AIL_MECH >> 2))] = pwdata;
        end

        // mode requests; while stopped only edit, parameter, offset after reset
        if (wr && paddr == `AIL_CTRL && !rst_req) begin
            unique case (pwdata[`AIL_MREQ+:6])
                AIL_MAN, AIL_AUTO, AIL_DIAG: begin
                    if (!st.es_act && !es_in) begin
                        next_st.mode = ail_mode_e'(pwdata[`AIL_MREQ+:6]);
                    end
                end
                AIL_EDIT, AIL_PARM, AIL_OFFS: begin
                    if (!st.es_show) begin
                        next_st.mode = ail_mode_e'(pwdata[`AIL_MREQ+:6]);
                    end
                end
                default: begin
                end
            endcase
        end

        if (foot_chuck && !st.es_act) begin
            next_st.chuck_clamp = !st.chuck_clamp;
        end
        if (foot_tail && !st.es_act) begin
            next_st.tail_adv = !st.tail_adv;
        end
        for (int i = 0; i < 4; i++) begin
            if (seq_done[i] && !st.es_act) begin
                next_st.unsure[i] = 1'b0;
            end
        end

        es_enter = es_in && !st.es_act;
        if (es_enter) begin
            next_st.es_act = 1'b1;
            next_st.es_show = 1'b1;
            next_st.saved = st.mode;
            next_st.chuck_clamp = 1'b0;
            next_st.tail_adv = 1'b0;
            next_st.unsure = next_st.unsure | seq_busy;
            next_st.seq_abort = |seq_busy;
            if ((man || st.mode == AIL_AUTO) && st.cfg[`AIL_CSE] && cust_present) begin
                next_st.cs = AIL_CS_RUN;
                next_st.cs_start = 1'b1;
            end
        end
        if (st.es_act) begin
            // output clamp runs every cycle so software cannot reopen them
            next_st.aux.spindle = 1'b0;
            next_st.aux.coolant = 1'b0;
            next_st.aux.lube = 1'b0;
            next_st.aux.tool_fwd = 1'b0;
            next_st.aux.tool_rev = 1'b0;
            if (st.cfg[`AIL_SCP]) begin
                next_st.aux.chuck = 1'b0;
                next_st.aux.tailstock = 1'b0;
            end
            if (rst_req) begin
                next_st.es_show = 1'b0;
                if (!es_in) begin
                    next_st.es_act = 1'b0;
                    next_st.mode = st.saved;
                    next_st.rel = '1;
                end
            end
        end

        unique case (st.cs)
            AIL_CS_IDLE: begin
            end
            AIL_CS_RUN: begin
                if (alarm_any || cust_step_stop) begin
                    next_st.cs = AIL_CS_IDLE;
                    next_st.cs_abort = 1'b1;
                end else if (cust_done) begin
                    next_st.cs = AIL_CS_IDLE;
                end
            end
        endcase

        // zero wait states: data and answer flopped in the setup cycle
        next_st.ready = rd_setup && !st.ready;
        if (rd_setup) begin
            next_st.err = !mapped;
            next_st.rdata = 32'h0;
            if (mapped) begin
                if (paddr == `AIL_CFG) begin
                    next_st.rdata = {24'h0, st.cfg};
                end else if (paddr == `AIL_CTRL) begin
                    next_st.rdata = {18'h0, st.mode, 8'h0};
                end else if (paddr == `AIL_OUT) begin
                    next_st.rdata = {24'h0, st.delay, st.aux};
                end else if (paddr == `AIL_STAT) begin
                    next_st.rdata = {10'h0, st.mode, st.s2_es, st.tail_adv, st.chuck_clamp,
                        st.cs == AIL_CS_RUN, st.unsure, st.es_show, st.es_act, st.nose_n,
                        st.nose_p, st.mech_n, st.mech_p, st.hl_neg, st.hl_pos};
                end else if (idx < 6'(`AIL_MECH >> 2)) begin
                    next_st.rdata = st.nose_lim[3'(idx - 6'(`AIL_NOSE >> 2))];
                end else begin
                    next_st.rdata = st.mech_lim[3'(idx - 6'(`AIL_MECH >> 2))];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.cfg <= `AIL_CFG_RST;
            st.mode <= AIL_EDIT;
            st.saved <= AIL_EDIT;
            st.cs <= AIL_CS_IDLE;
            for (int i = 0; i < 3; i++) begin
                st.nose_lim[2*i] <= `AIL_LPOS_RST;
                st.nose_lim[2*i+1] <= `AIL_LNEG_RST;
                st.mech_lim[2*i] <= `AIL_LPOS_RST;
                st.mech_lim[2*i+1] <= `AIL_LNEG_RST;
            end
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;
    assign aux_out = st.aux;
    assign delay_interface_out = st.delay;
    assign hard_stop = st.hard_stop;
    assign decel_stop = st.decel_stop;
    assign prog_halt = st.prog_halt;
    assign pos_block = st.pos_block;
    assign neg_block = st.neg_block;
    assign estop_alarm = st.es_show;
    assign seq_abort = st.seq_abort;
    assign pos_uncertain = st.unsure;
    assign chuck_clamp_state = st.chuck_clamp;
    assign tailstock_advance_state = st.tail_adv;
    assign release_act = st.rel;
    assign cust_start = st.cs_start;
    assign cust_abort = st.cs_abort;
    assign cust_run = st.cs[1];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_hl_disabled: assert property (!st.cfg[`AIL_HLD] |=> !st.hl_pos && !st.hl_neg)
        else $error("hard limit alarm while detection off");
    chk_lvl_high: assert property (st.cfg[`AIL_HLD] && st.cfg[`AIL_LVL] && st.s2_lim[1]
        |=> st.hl_pos)
        else $error("open chain missed at level one");
    chk_lvl_low: assert property (st.cfg[`AIL_HLD] && !st.cfg[`AIL_LVL] && !st.s2_lim[0]
        |=> st.hl_neg)
        else $error("closed switch missed at level zero");
    chk_abrupt_halt: assert property ((st.hl_pos || st.hl_neg)
        && st.cfg[`AIL_STM] |=> hard_stop)
        else $error("no abrupt halt in stop mode");
    chk_pos_block: assert property (st.hl_pos |=> pos_block ##1 1'b1)
        else $error("positive motion not blocked");
    chk_mech_soft: assert property (st.cfg[`AIL_MSE] && m_rng[1]
        |=> st.mech_p ##1 decel_stop)
        else $error("mechanical overtravel not raised");
    chk_stop_aux: assert property (st.es_act |=> !aux_out.spindle && !aux_out.coolant
        && !aux_out.lube)
        else $error("spindle or coolant left on in stop");
    chk_delay_hold: assert property (st.es_act |=> $stable(delay_interface_out))
        else $error("delay output changed in stop");
    chk_mode_refuse: assert property (st.s2_es |=> !($changed(st.mode)
        && st.mode inside {AIL_MAN, AIL_AUTO, AIL_DIAG}))
        else $error("operating mode entered while stop held");
    chk_sync_depth: assert property (##3 st.s2_es == $past(emergency_stop_in, 2))
        else $error("stop input not two stages deep");
    chk_scope_clear: assert property (st.es_act && st.cfg[`AIL_SCP]
        |=> !aux_out.chuck && !aux_out.tailstock)
        else $error("chuck or tailstock left on with full scope");
    chk_tool_drop: assert property (st.es_act |=> !aux_out.tool_fwd && !aux_out.tool_rev)
        else $error("tool post rotation left on in stop");
    chk_release_act: assert property (st.es_act && rst_req && !es_in
        |=> release_act == 4'hF)
        else $error("release actions not pulsed");

    cov_stop_entry: cover property (!st.es_act ##1 st.es_act);
    cov_custom_run: cover property (cust_start ##[1:20] cust_abort);
    cov_limit_hit: cover property (st.hl_pos && hard_stop);
    cov_release: cover property (release_act.prog_init);
    cov_full_scope: cover property (st.es_act && st.cfg[`AIL_SCP]);
endmodule

// ---- bench/ail_far_side.sv ----
// far-side model: shared limit switch chains, emergency button and sequence actuators
`timescale 1ns/1ps
module ail_far_side (
    input wire logic hit_pos,
    input wire logic hit_neg,
    input wire logic nc_wiring,
    input wire logic button_down,
    input wire logic [3:0] seq_run,
    output logic pos_limit_in,
    output logic neg_limit_in,
    output logic emergency_stop_in,
    output logic [3:0] seq_busy
);
    // series closed chain opens on a hit; parallel open switches pull the line low on a hit
    assign pos_limit_in = nc_wiring ? hit_pos : ~hit_pos;
    assign neg_limit_in = nc_wiring ? hit_neg : ~hit_neg;
    // closed contact breaks when pressed, so the input reads high while stopped
    assign emergency_stop_in = button_down;
    assign seq_busy = seq_run;
endmodule

// ---- bench/test_axis_limit_estop_interlock.sv ----
// self-checking bench for the limit and emergency-stop interlock
`timescale 1ns/1ps
`include "ail_params.svh"
module test_axis_limit_estop_interlock;
    import ail_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pos_limit_in, neg_limit_in, emergency_stop_in;
    ail_vec_t mach_crd, nose_crd;
    ail_jog_s jog;
    logic [3:0] seq_busy, seq_done, seq_run, pos_uncertain;
    logic foot_chuck, foot_tail, cust_present, cust_step_stop, cust_done;
    ail_aux_s aux_out;
    ail_rel_s release_act;
    logic delay_interface_out, hard_stop, decel_stop, prog_halt, pos_block, neg_block;
    logic estop_alarm, seq_abort, chuck_clamp_state, tailstock_advance_state;
    logic cust_start, cust_abort, cust_run, hit_pos, hit_neg, nc_wiring, button_down;
    int err_total, checked, rel_cnt;

    ail_interlock u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pos_limit_in(pos_limit_in), .neg_limit_in(neg_limit_in),
        .emergency_stop_in(emergency_stop_in), .mach_crd(mach_crd), .nose_crd(nose_crd),
        .jog(jog), .seq_busy(seq_busy), .seq_done(seq_done), .foot_chuck(foot_chuck),
        .foot_tail(foot_tail), .cust_present(cust_present), .cust_step_stop(cust_step_stop),
        .cust_done(cust_done), .aux_out(aux_out), .delay_interface_out(delay_interface_out),
        .hard_stop(hard_stop), .decel_stop(decel_stop), .prog_halt(prog_halt),
        .pos_block(pos_block), .neg_block(neg_block), .estop_alarm(estop_alarm),
        .seq_abort(seq_abort), .pos_uncertain(pos_uncertain),
        .chuck_clamp_state(chuck_clamp_state),
        .tailstock_advance_state(tailstock_advance_state), .release_act(release_act),
        .cust_start(cust_start), .cust_abort(cust_abort), .cust_run(cust_run));

    ail_far_side u_far (.hit_pos(hit_pos), .hit_neg(hit_neg), .nc_wiring(nc_wiring),
        .button_down(button_down), .seq_run(seq_run), .pos_limit_in(pos_limit_in),
        .neg_limit_in(neg_limit_in), .emergency_stop_in(emergency_stop_in),
        .seq_busy(seq_busy));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // release pulses are one cycle wide and may land inside a bus transfer, so count them
    always @(posedge pclk) begin
        if (release_act === 4'hF) rel_cnt <= rel_cnt + 1;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic t_regs();
        apb(0, `AIL_CFG, 0);
        chk("cfg", 32'h1B, q);
        apb(0, `AIL_NOSE, 0);
        chk("nose_z_pos", 32'h7FFFFFFF, q);
        apb(0, `AIL_MECH + 8'h04, 0);
        chk("mech_z_neg", 32'h80000000, q);
        apb(1, `AIL_NOSE + 8'h14, 32'hFFFF1234);
        apb(0, `AIL_NOSE + 8'h14, 0);
        chk("nose_y_neg", 32'hFFFF1234, q);
        apb(1, `AIL_NOSE + 8'h01, 32'h0);
        apb(0, `AIL_NOSE, 0);
        chk("unaligned_ignored", 32'h7FFFFFFF, q);
        apb(0, `AIL_END, 0);
        chk("unmapped_err", 1, e);
    endtask

    task automatic t_hard();
        apb(1, `AIL_OUT, 32'h60);
        hit_pos <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("pos_block", 1, pos_block);
        chk("neg_block", 0, neg_block);
        chk("prog_halt", 1, prog_halt);
        chk("decel_mode0", 1, decel_stop);
        chk("aux_kept", 32'h60, aux_out);
        apb(1, `AIL_CTRL, 32'h200);
        hit_pos <= 1'b0;
        jog <= 6'b000001;
        repeat (6) @(posedge pclk);
        jog <= 6'b0;
        chk("pos_cleared", 0, pos_block);
    endtask

    task automatic t_level();
        apb(1, `AIL_CFG, 32'h1C);
        nc_wiring <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1, `AIL_CFG, 32'h1D);
        repeat (6) @(posedge pclk);
        chk("no_idle_alarm", 0, neg_block);
        hit_neg <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("neg_block", 1, neg_block);
        chk("hard_mode1", 1, hard_stop);
        apb(1, `AIL_CFG, 32'h1C);
        repeat (6) @(posedge pclk);
        chk("detect_off", 0, neg_block);
        hit_neg <= 1'b0;
        nc_wiring <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1, `AIL_CFG, 32'h1B);
    endtask

    task automatic t_soft();
        apb(1, `AIL_MECH, 32'd100);
        mach_crd[0] <= 32'd101;
        repeat (6) @(posedge pclk);
        chk("soft_decel", 1, decel_stop);
        chk("soft_no_halt", 0, hard_stop);
        apb(1, `AIL_NOSE + 8'h0C, 32'hFFFFFFCE);
        nose_crd[1] <= 32'hFFFFFFCD;
        repeat (6) @(posedge pclk);
        apb(0, `AIL_STAT, 0);
        chk("soft_flags", 32'h9, {28'h0, q[5:2]});
        apb(1, `AIL_CFG, 32'h13);
        mach_crd[0] <= 32'd0;
        apb(0, `AIL_STAT, 0);
        chk("mech_off", 32'h8, {28'h0, q[5:2]});
        nose_crd[1] <= 32'd0;
        jog <= 6'b010000;
        repeat (6) @(posedge pclk);
        jog <= 6'b0;
        apb(0, `AIL_STAT, 0);
        chk("nose_cleared", 0, {28'h0, q[5:2]});
        apb(1, `AIL_CFG, 32'h1B);
    endtask

    task automatic t_estop(input logic scope);
        int n;
        int r0;
        apb(1, `AIL_CFG, 32'h5B | {26'h0, scope, 5'h0});
        apb(1, `AIL_CTRL, 32'h200);
        apb(1, `AIL_OUT, 32'hFF);
        seq_run <= 4'h1;
        cust_present <= 1'b1;
        button_down <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (estop_alarm !== 1'b1 && n < 10);
        chk("seq_abort", 1, seq_abort);
        chk("cust_start", 1, cust_start);
        seq_run <= 4'h0;
        repeat (2) @(posedge pclk);
        chk("aux_cleared", scope ? 32'h0 : 32'h0C, aux_out);
        chk("delay_held", 1, delay_interface_out);
        chk("feed_stop", 1, hard_stop);
        chk("prog_halt", 1, prog_halt);
        chk("uncertain", 32'h1, pos_uncertain);
        chk("chuck_released", 0, chuck_clamp_state);
        chk("tail_retracted", 0, tailstock_advance_state);
        chk("cust_run", 1, cust_run);
        cust_step_stop <= 1'b1;
        @(posedge pclk);
        cust_step_stop <= 1'b0;
        @(posedge pclk);
        chk("cust_abort", 1, cust_abort);
        @(posedge pclk);
        chk("cust_aborted", 0, cust_run);
        apb(1, `AIL_CTRL, 32'h400);
        apb(0, `AIL_CTRL, 0);
        chk("auto_refused", 0, q[10]);
        button_down <= 1'b0;
        repeat (6) @(posedge pclk);
        r0 = rel_cnt;
        apb(1, `AIL_CTRL, 32'h1);
        repeat (2) @(posedge pclk);
        chk("release_pulse", 32'(r0 + 1), 32'(rel_cnt));
        apb(0, `AIL_CTRL, 0);
        chk("mode_back", 32'h02, {26'h0, q[13:8]});
        {foot_chuck, foot_tail, seq_done} <= 6'h31;
        @(posedge pclk);
        {foot_chuck, foot_tail, seq_done} <= 6'h00;
        repeat (2) @(posedge pclk);
        chk("chuck_clamp", 1, chuck_clamp_state);
        chk("tail_adv", 1, tailstock_advance_state);
        chk("uncertain_clr", 0, pos_uncertain);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, hit_pos, hit_neg, button_down} = '0;
        {foot_chuck, foot_tail, cust_present, cust_step_stop, cust_done} = '0;
        {paddr, pwdata, mach_crd, nose_crd, jog, seq_done, seq_run} = '0;
        nc_wiring = 1'b1;
        {err_total, checked, rel_cnt} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_hard();
        t_level();
        t_soft();
        t_estop(1'b0);
        t_estop(1'b1);
        report_and_stop();
    end

    // the sequence needs well under a thousand cycles; this bound only cuts a hang
    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        report_and_stop();
    end
endmodule
